/* File: rtl/ppdc_regs.svh */
// constants for the port pin drive control block
// assumes inclusion by bare name from rtl files
`ifndef PPDC_REGS_SVH
`define PPDC_REGS_SVH
`define PPDC_PINS 8
`define PPDC_SRC_W 5
`define PPDC_RST_LATCH 8'h00
`define PPDC_RST_SEL 40'h00_0000_0000
`define PPDC_RST_CCD 8'h00
`define PPDC_RST_SRC 5'h00
`endif

/* File: rtl/ppdc_pkg.sv */
// types for the port pin drive control block
// assumes nothing beyond a SystemVerilog compiler
package ppdc_pkg;
    // 0 selects the port latch, others pick a routed peripheral output
    typedef logic [4:0] ppdc_src_t;
    typedef enum logic [1:0]
    {
        PPDC_DRV_NORMAL = 2'b01,
        PPDC_DRV_CCD = 2'b10
    } ppdc_drv_t;
endpackage

/* File: rtl/ppdc_port_drive.sv */
// per-pin output control of one general-purpose port
// assumes all inputs synchronous to clk; software writes come as plain strobes
//
// Summary of operation
// RL1: pin select and global enable turn on ccd
// RL2: cleared pin select disables ccd regardless
// RL3: software never sets selects with enable clear
// RL4: separate high and low side selects per pin
// RL5: after reset pins drive from port latch
// RL6: peripherals reach pins only through routing
// RL7: digital outputs still drive in analog mode
`timescale 1ns/1ps
`include "ppdc_regs.svh"

module ppdc_port_drive #(
    parameter int PINS = `PPDC_PINS,
    parameter int NPERIPH = 31
)(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // software writes
    input wire logic latch_we,
    input wire logic [PINS-1:0] latch_wdata,
    input wire logic route_we,
    input wire logic [$clog2(PINS)-1:0] route_pin,
    input wire ppdc_pkg::ppdc_src_t route_src,
    input wire logic ccd_we,
    input wire logic [PINS-1:0] ccd_high_side_pin_select_wdata,
    input wire logic [PINS-1:0] ccd_low_side_pin_select_wdata,
    input wire logic ccd_global_enable_wdata,
    input wire logic [PINS-1:0] analog_mode,
    // peripheral outputs offered to the routing
    input wire logic [NPERIPH-1:0] periph_out,
    // pin drive
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_ccd_high_on,
    output logic [PINS-1:0] pin_ccd_low_on,
    // readback
    output logic [PINS-1:0] latch_rd,
    output logic ccd_global_enable_rd,
    output logic ccd_misuse
);
    import ppdc_pkg::*;

    // port latch
    logic [PINS-1:0] latch_q;
    logic [PINS-1:0] latch_d;
    // per-pin source codes, 0 being the latch
    ppdc_src_t sel_q [PINS];
    ppdc_src_t sel_d [PINS];
    // current-controlled drive selects and the global enable
    logic [PINS-1:0] hs_q;
    logic [PINS-1:0] hs_d;
    logic [PINS-1:0] ls_q;
    logic [PINS-1:0] ls_d;
    logic en_q;
    logic en_d;
    // registered pin drive and status
    logic [PINS-1:0] out_q;
    logic [PINS-1:0] out_d;
    logic [PINS-1:0] ccdh_q;
    logic [PINS-1:0] ccdh_d;
    logic [PINS-1:0] ccdl_q;
    logic [PINS-1:0] ccdl_d;
    logic misuse_q;
    logic misuse_d;

    // a write strobe loads new data, otherwise the word holds
    function automatic logic [PINS-1:0] load_word(
        input logic we,
        input logic [PINS-1:0] wdata,
        input logic [PINS-1:0] cur
    );
        logic [PINS-1:0] nxt;
        nxt = cur;
        if (we)
        begin
            nxt = wdata;
        end
        return nxt;
    endfunction

    // pick the source for one pin; unknown codes fall back to the latch
    function automatic logic route_bit(
        input ppdc_src_t s,
        input logic lat,
        input logic [NPERIPH-1:0] p
    );
        logic pick;
        pick = lat;
        if (s != 5'h00 && int'(s) <= NPERIPH)
        begin
            pick = p[int'(s) - 1]; // RL6
        end
        return pick;
    endfunction

    // a select only takes effect while the global enable is set
    function automatic logic [PINS-1:0] ccd_gate(
        input logic [PINS-1:0] sel,
        input logic en
    );
        logic [PINS-1:0] gated;
        gated = sel & {PINS{en}};
        return gated;
    endfunction

    // port latch group
    always_comb
    begin
        latch_d = load_word(latch_we, latch_wdata, latch_q);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            latch_q <= PINS'(`PPDC_RST_LATCH); // RL5
        end
        else
        begin
            latch_q <= latch_d;
        end
    end

    // source select group: one pin changes per route write
    always_comb
    begin
        for (int i = 0; i < PINS; i++)
        begin
            sel_d[i] = sel_q[i];
            if (route_we && int'(route_pin) == i)
            begin
                sel_d[i] = route_src; // RL6
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < PINS; i++)
            begin
                sel_q[i] <= `PPDC_RST_SRC; // RL5
            end
        end
        else
        begin
            for (int i = 0; i < PINS; i++)
            begin
                sel_q[i] <= sel_d[i];
            end
        end
    end

    // drive select group; both sides load from one strobe
    always_comb
    begin
        hs_d = load_word(ccd_we, ccd_high_side_pin_select_wdata, hs_q); // RL4
        ls_d = load_word(ccd_we, ccd_low_side_pin_select_wdata, ls_q); // RL4
        en_d = en_q;
        if (ccd_we)
        begin
            en_d = ccd_global_enable_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hs_q <= PINS'(`PPDC_RST_CCD);
            ls_q <= PINS'(`PPDC_RST_CCD);
            en_q <= 1'b0;
        end
        else
        begin
            hs_q <= hs_d;
            ls_q <= ls_d;
            en_q <= en_d;
        end
    end

    // pin output group
    always_comb
    begin
        for (int i = 0; i < PINS; i++)
        begin
            // analog mode deliberately ignored: digital drive persists
            out_d[i] = route_bit(sel_q[i], latch_q[i], periph_out); // RL5 RL7
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_q <= PINS'(`PPDC_RST_LATCH); // RL5
        end
        else
        begin
            out_q <= out_d;
        end
    end

    // drive enable group; gating uses the stored enable, so a select
    // written while the enable is clear never reaches the pin
    always_comb
    begin
        ccdh_d = ccd_gate(hs_q, en_q); // RL1 RL2
        ccdl_d = ccd_gate(ls_q, en_q); // RL1 RL2
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ccdh_q <= PINS'(`PPDC_RST_CCD);
            ccdl_q <= PINS'(`PPDC_RST_CCD);
        end
        else
        begin
            ccdh_q <= ccdh_d;
            ccdl_q <= ccdl_d;
        end
    end

    // status group: flags the undefined combination software must avoid
    always_comb
    begin
        misuse_d = |(hs_q | ls_q) && !en_q; // RL3
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            misuse_q <= 1'b0;
        end
        else
        begin
            misuse_q <= misuse_d;
        end
    end

    assign pin_out = out_q;
    assign pin_ccd_high_on = ccdh_q;
    assign pin_ccd_low_on = ccdl_q;
    assign latch_rd = latch_q;
    assign ccd_global_enable_rd = en_q;
    assign ccd_misuse = misuse_q;
endmodule

/* File: verification/ppdc_port_drive_props.sv */
// assertions for the port pin drive block
// assumes binding to ppdc_port_drive, one clock domain
`timescale 1ns/1ps
module ppdc_props #(
    parameter int PINS = 8,
    parameter int NPERIPH = 31
)(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // writes
    input wire logic latch_we,
    input wire logic [PINS-1:0] latch_wdata,
    input wire logic route_we,
    input wire logic [$clog2(PINS)-1:0] route_pin,
    input wire ppdc_pkg::ppdc_src_t route_src,
    input wire logic ccd_we,
    input wire logic [PINS-1:0] ccd_high_side_pin_select_wdata,
    input wire logic [PINS-1:0] ccd_low_side_pin_select_wdata,
    input wire logic ccd_global_enable_wdata,
    input wire logic [NPERIPH-1:0] periph_out,
    // outputs
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_ccd_high_on,
    input wire logic [PINS-1:0] pin_ccd_low_on,
    input wire logic [PINS-1:0] latch_rd,
    input wire logic ccd_global_enable_rd,
    input wire logic ccd_misuse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // latch path only holds until a route write lands
    logic routed_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            routed_q <= 1'b0;
        end
        else if (route_we)
        begin
            routed_q <= 1'b1;
        end
    end
    property p_high; ccd_we |-> ##2 pin_ccd_high_on == ($past(ccd_high_side_pin_select_wdata, 2)
        & {PINS{$past(ccd_global_enable_wdata, 2)}}); endproperty
    a_high: assert property (p_high) else $error("high side drive wrong");
    property p_low; ccd_we |-> ##2 pin_ccd_low_on == ($past(ccd_low_side_pin_select_wdata, 2)
        & {PINS{$past(ccd_global_enable_wdata, 2)}}); endproperty
    a_low: assert property (p_low) else $error("low side drive wrong");
    property p_gate; (|(pin_ccd_low_on | pin_ccd_high_on)) |-> $past(ccd_global_enable_rd);
    endproperty
    a_gate: assert property (p_gate) else $error("drive without enable");
    property p_latch_rd; latch_we |-> ##1 latch_rd == $past(latch_wdata); endproperty
    a_latch_rd: assert property (p_latch_rd) else $error("latch readback wrong");
    property p_enable_rd; ccd_we |-> ##1 ccd_global_enable_rd == $past(ccd_global_enable_wdata);
    endproperty
    a_enable_rd: assert property (p_enable_rd) else $error("enable readback wrong");
    property p_misuse; ccd_we |-> ##2 ccd_misuse == ((|($past(ccd_high_side_pin_select_wdata, 2)
        | $past(ccd_low_side_pin_select_wdata, 2))) && !$past(ccd_global_enable_wdata, 2));
    endproperty
    a_misuse: assert property (p_misuse) else $error("misuse flag wrong");
    property p_latch; !routed_q |-> pin_out == $past(latch_rd); endproperty
    a_latch: assert property (p_latch) else $error("pin not from latch");
    property p_route; route_we && route_pin == 0 && route_src == 5'h01
        |-> ##2 pin_out[0] == $past(periph_out[0]); endproperty
    a_route: assert property (p_route) else $error("routed output wrong");
endmodule
bind ppdc_port_drive ppdc_props #(.PINS(PINS), .NPERIPH(NPERIPH)) i_props (
    .clk(clk),
    .rst_n(rst_n),
    .latch_we(latch_we),
    .latch_wdata(latch_wdata),
    .route_we(route_we),
    .route_pin(route_pin),
    .route_src(route_src),
    .ccd_we(ccd_we),
    .ccd_high_side_pin_select_wdata(ccd_high_side_pin_select_wdata),
    .ccd_low_side_pin_select_wdata(ccd_low_side_pin_select_wdata),
    .ccd_global_enable_wdata(ccd_global_enable_wdata),
    .periph_out(periph_out),
    .pin_out(pin_out),
    .pin_ccd_high_on(pin_ccd_high_on),
    .pin_ccd_low_on(pin_ccd_low_on),
    .latch_rd(latch_rd),
    .ccd_global_enable_rd(ccd_global_enable_rd),
    .ccd_misuse(ccd_misuse)
);

/* File: verification/port_pin_drive_control_tb.sv */
// self-checking bench for the port pin drive block
// assumes the checker file is compiled beside it
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("mismatch %0t got %h exp %h", $time, a, b); end end
module port_pin_drive_control_tb;
    import ppdc_pkg::*;
    logic clk = 0, rst_n = 0, latch_we = 0, route_we = 0, ccd_we = 0, mk = 0, rt = 0;
    logic ccd_global_enable_wdata = 0, ccd_global_enable_rd, ccd_misuse;
    logic [7:0] latch_wdata = 0, analog_mode = 0, pin_out, pin_ccd_high_on, pin_ccd_low_on;
    logic [7:0] ccd_high_side_pin_select_wdata = 0, ccd_low_side_pin_select_wdata = 0, latch_rd;
    logic [2:0] route_pin = 0;
    logic [1:0] m = 0;
    ppdc_src_t route_src = 5'h01;
    logic [30:0] periph_out = 0;
    logic [31:0] d;
    // pin data, both drive enables and the misuse flag, two edges after each write edge
    logic [24:0] q[$], exp_v, got;
    int cyc = 0, n_mismatch = 0, cmp_count = 0, i;
    ppdc_port_drive i_dut (.clk, .rst_n, .latch_we, .latch_wdata, .route_we, .route_pin,
        .route_src, .ccd_we, .ccd_high_side_pin_select_wdata, .ccd_low_side_pin_select_wdata,
        .ccd_global_enable_wdata, .analog_mode, .periph_out, .pin_out, .pin_ccd_high_on,
        .pin_ccd_low_on, .latch_rd, .ccd_global_enable_rd, .ccd_misuse);
    assign got = {pin_out, pin_ccd_high_on, pin_ccd_low_on, ccd_misuse};
    always #4 clk = ~clk;
    always @(posedge clk) m <= {m[0], mk};
    always @(negedge clk)
    begin
        if (m[1])
        begin
            exp_v = q.pop_front();
            `CHK(got, exp_v)
        end
    end
    always @(posedge clk) if (++cyc == 400) begin n_mismatch++; end_of_test(); end
    task end_of_test;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        d = $urandom(31);
        repeat (5) @(posedge clk);
        rst_n <= 1;
        periph_out <= 31'($urandom);
        // back-to-back writes; selects only with enable set
        for (i = 0; i < 24; i++)
        begin
            @(posedge clk);
            d = $urandom;
            {latch_we, ccd_we, ccd_global_enable_wdata, mk, route_we} <= {2'b11, d[0], 1'b1, i == 12};
            {latch_wdata, analog_mode, ccd_high_side_pin_select_wdata,
                ccd_low_side_pin_select_wdata} <= {d[31:16], d[15:8] & {8{d[0]}}, d[7:0] & {8{d[0]}}};
            rt = rt | (i == 12);
            q.push_back({d[31:25], rt ? periph_out[0] : d[24],
                d[15:8] & {8{d[0]}}, d[7:0] & {8{d[0]}}, 1'b0});
        end
        @(posedge clk);
        {latch_we, ccd_we, mk, route_we} <= 4'h0;
        repeat (4) @(posedge clk);
        end_of_test();
    end
endmodule
